// ### design/bst_tap.sv
// Summary of operation
// - Inputs on test-clock rise, output on fall
// - Mode select and data in pulled high
// - Shift in at MSB, out at LSB
// - Serial out driven only in shift states
// - Five mode-select highs reset the controller
// - Reset loads identification instruction
// - Capture-IR loads 01 into low bits
// - Three-bit instruction, effective at Update-IR
// - Instruction selects exactly one data register
// - Bypass bit captures zero, shifts in Shift-DR
// - Boundary register captures pins, then shifts
// - Identification capture loads fixed 32-bit code
// - Float-sample floats memory outputs until replaced
// - Sample snapshot shifts out while preload shifts in
// - Preload latches pattern at Update-DR
// - External test drives preloaded values to pins
// - Cell 47 enables read outputs under external test
// - Enable cell written by shift, latched Update-DR
// - Enable latch preset low at reset
// - Instruction encodings as fixed codes
// - Transitions follow mode select at rise
`timescale 1ns/1ps
module bst_tap (
   input  wire logic                      i_clk,
   input  wire logic                      i_resetn,
   input  wire logic                      i_tck,
   input  wire logic                      i_tms,
   input  wire logic                      i_tdi,
   output logic                           o_tdo,
   output logic                           o_tdo_oe,
   input  wire logic [bst_pkg::BSR_W-1:0] i_pins,
   output logic [bst_pkg::BSR_W-1:0]      o_pins_pre,
   output logic                           o_extest,
   output logic                           o_q_oe,
   output logic                           o_mon_valid,
   input  wire logic                      i_mon_ready,
   output logic [bst_pkg::MON_W-1:0]      o_mon_data,
   output logic                           o_mon_ovf
);

   typedef struct packed {
      logic                         tck_s1;
      logic                         tck_s2;
      logic                         tck_p;
      logic                         tms_s1;
      logic                         tms_s2;
      logic                         tdi_s1;
      logic                         tdi_s2;
      logic [bst_pkg::BSR_W-1:0]    pin_s1;
      logic [bst_pkg::BSR_W-1:0]    pin_s2;
      bst_pkg::bst_state_t          st;
      logic [bst_pkg::IR_W-1:0]     ir_sh;
      logic [bst_pkg::IR_W-1:0]     ir;
      logic                         byp;
      logic [bst_pkg::ID_W-1:0]     idr;
      logic [bst_pkg::BSR_W-1:0]    bsr;
      logic [bst_pkg::BSR_W-1:0]    pre;
      logic                         tdo;
      logic                         tdo_oe;
      logic [bst_pkg::MON_W-1:0]    mon;
      logic [bst_pkg::MON_CW-1:0]   mon_cnt;
      logic                         mon_vld;
      logic                         ovf;
   } bst_tap_t;

   bst_tap_t s_q, s_d;
   logic     rise;
   logic     fall;
   logic     bsr_ins;
   logic     dr_lsb;
   logic     fifo_rdy;
   bst_pkg::bst_state_t nxt;

   assign rise = s_q.tck_s2 && !s_q.tck_p;
   assign fall = !s_q.tck_s2 && s_q.tck_p;
   assign bsr_ins = (s_q.ir == bst_pkg::INS_EXTEST) || (s_q.ir == bst_pkg::INS_SAMPLE)
                 || (s_q.ir == bst_pkg::INS_SAMPZ);

   // Reserved codes fall back to the bypass bit so the chain stays one bit long
   always_comb begin
      case (s_q.ir)
         bst_pkg::INS_IDCODE: dr_lsb = s_q.idr[0];
         bst_pkg::INS_EXTEST,
         bst_pkg::INS_SAMPLE,
         bst_pkg::INS_SAMPZ:  dr_lsb = s_q.bsr[0];
         default:             dr_lsb = s_q.byp;
      endcase
   end

   // Sixteen-state walk driven by sampled mode select
   always_comb begin
      case (s_q.st)
         bst_pkg::ST_TLR:    nxt = s_q.tms_s2 ? bst_pkg::ST_TLR    : bst_pkg::ST_RTI;
         bst_pkg::ST_RTI:    nxt = s_q.tms_s2 ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
         bst_pkg::ST_SEL_DR: nxt = s_q.tms_s2 ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
         bst_pkg::ST_CAP_DR: nxt = s_q.tms_s2 ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_SH_DR:  nxt = s_q.tms_s2 ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_EX1_DR: nxt = s_q.tms_s2 ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PA_DR;
         bst_pkg::ST_PA_DR:  nxt = s_q.tms_s2 ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PA_DR;
         bst_pkg::ST_EX2_DR: nxt = s_q.tms_s2 ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_UPD_DR: nxt = s_q.tms_s2 ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
         bst_pkg::ST_SEL_IR: nxt = s_q.tms_s2 ? bst_pkg::ST_TLR    : bst_pkg::ST_CAP_IR;
         bst_pkg::ST_CAP_IR: nxt = s_q.tms_s2 ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_SH_IR:  nxt = s_q.tms_s2 ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_EX1_IR: nxt = s_q.tms_s2 ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PA_IR;
         bst_pkg::ST_PA_IR:  nxt = s_q.tms_s2 ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PA_IR;
         bst_pkg::ST_EX2_IR: nxt = s_q.tms_s2 ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_UPD_IR: nxt = s_q.tms_s2 ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
         default:            nxt = bst_pkg::ST_TLR;
      endcase
   end

   always_comb begin
      s_d        = s_q;
      s_d.tck_s1 = i_tck;
      s_d.tck_s2 = s_q.tck_s1;
      s_d.tck_p  = s_q.tck_s2;
      s_d.tms_s1 = i_tms;
      s_d.tms_s2 = s_q.tms_s1;
      s_d.tdi_s1 = i_tdi;
      s_d.tdi_s2 = s_q.tdi_s1;
      s_d.pin_s1 = i_pins;
      s_d.pin_s2 = s_q.pin_s1;
      if (rise) begin
         s_d.st = nxt;
         case (s_q.st)
            bst_pkg::ST_CAP_IR: s_d.ir_sh = {bst_pkg::IR_CAP_MSB, bst_pkg::IR_CAP_LSB};
            bst_pkg::ST_SH_IR:  s_d.ir_sh = {s_q.tdi_s2, s_q.ir_sh[bst_pkg::IR_W-1:1]};
            bst_pkg::ST_CAP_DR: begin
               s_d.byp = bst_pkg::BYP_CAP;
               if (s_q.ir == bst_pkg::INS_IDCODE) begin
                  s_d.idr = bst_pkg::ID_CODE;
               end
               if (bsr_ins) begin
                  s_d.bsr = s_q.pin_s2;
               end
            end
            bst_pkg::ST_SH_DR: begin
               case (s_q.ir)
                  bst_pkg::INS_IDCODE:
                     s_d.idr = {s_q.tdi_s2, s_q.idr[bst_pkg::ID_W-1:1]};
                  bst_pkg::INS_EXTEST,
                  bst_pkg::INS_SAMPLE,
                  bst_pkg::INS_SAMPZ:
                     s_d.bsr = {s_q.tdi_s2, s_q.bsr[bst_pkg::BSR_W-1:1]};
                  default:
                     s_d.byp = s_q.tdi_s2;
               endcase
               // Shifted-in data is also copied out to the monitor stream, except while a finished byte waits: that bit is dropped and sets overflow
               if (!s_q.mon_vld) begin
                  s_d.mon     = {s_q.tdi_s2, s_q.mon[bst_pkg::MON_W-1:1]};
                  s_d.mon_cnt = s_q.mon_cnt + 1'b1;
                  if (&s_q.mon_cnt) begin
                     s_d.mon_vld = 1'b1;
                  end
               end else begin
                  s_d.ovf = 1'b1;
               end
            end
            default: ;
         endcase
      end
      if (fall) begin
         // Updates happen on the falling edge so pins move half a cycle after the rise that enters the update state
         if (s_q.st == bst_pkg::ST_UPD_IR) begin
            s_d.ir = s_q.ir_sh;
         end
         if (s_q.st == bst_pkg::ST_UPD_DR
             && (s_q.ir == bst_pkg::INS_EXTEST || s_q.ir == bst_pkg::INS_SAMPLE)) begin
            s_d.pre = s_q.bsr;
         end
         if (s_q.st == bst_pkg::ST_SH_IR) begin
            s_d.tdo    = s_q.ir_sh[0];
            s_d.tdo_oe = 1'b1;
         end else if (s_q.st == bst_pkg::ST_SH_DR) begin
            s_d.tdo    = dr_lsb;
            s_d.tdo_oe = 1'b1;
         end else begin
            s_d.tdo_oe = 1'b0;
         end
      end
      if (s_q.st == bst_pkg::ST_TLR) begin
         s_d.ir              = bst_pkg::INS_IDCODE;
         s_d.pre[bst_pkg::OE_BIT] = bst_pkg::OE_PRESET;
      end
      if (s_q.mon_vld && fifo_rdy) begin
         s_d.mon_vld = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_q        <= '0;
         s_q.tms_s1 <= bst_pkg::PULL_UP;
         s_q.tms_s2 <= bst_pkg::PULL_UP;
         s_q.tdi_s1 <= bst_pkg::PULL_UP;
         s_q.tdi_s2 <= bst_pkg::PULL_UP;
         s_q.st     <= bst_pkg::ST_TLR;
         s_q.ir     <= bst_pkg::INS_IDCODE;
         s_q.tdo_oe <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   bst_fifo #(
      .W (bst_pkg::MON_W),
      .D (bst_pkg::MON_D)
   ) u_mon_fifo (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_valid  (s_q.mon_vld),
      .o_ready  (fifo_rdy),
      .i_data   (s_q.mon),
      .o_valid  (o_mon_valid),
      .i_ready  (i_mon_ready),
      .o_data   (o_mon_data)
   );

   assign o_tdo      = s_q.tdo;
   assign o_tdo_oe   = s_q.tdo_oe;
   assign o_pins_pre = s_q.pre;
   assign o_extest   = (s_q.ir == bst_pkg::INS_EXTEST);
   assign o_mon_ovf  = s_q.ovf;

   // Float-sample wins; normal operation leaves the read outputs enabled
   always_comb begin
      case (s_q.ir)
         bst_pkg::INS_SAMPZ:  o_q_oe = 1'b0;
         bst_pkg::INS_EXTEST: o_q_oe = s_q.pre[bst_pkg::OE_BIT];
         default:             o_q_oe = 1'b1;
      endcase
   end

   // Helper: consecutive rising edges with mode select high
   logic [2:0] tms_run_q;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tms_run_q <= 3'h0;
      end else if (rise) begin
         if (!s_q.tms_s2) begin
            tms_run_q <= 3'h0;
         end else if (tms_run_q != 3'(bst_pkg::RST_TMS_N)) begin
            tms_run_q <= tms_run_q + 3'h1;
         end
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   property p_five_reset;
      (tms_run_q == 3'(bst_pkg::RST_TMS_N)) |-> (s_q.st == bst_pkg::ST_TLR);
   endproperty
   a_five_reset: assert property (p_five_reset) else $error("five highs did not reset");

   property p_tlr_ir;
      (s_q.st == bst_pkg::ST_TLR) |=> (s_q.ir == bst_pkg::INS_IDCODE);
   endproperty
   a_tlr_ir: assert property (p_tlr_ir) else $error("reset state lost id instruction");

   property p_cap_ir;
      rise && (s_q.st == bst_pkg::ST_CAP_IR)
         |=> (s_q.ir_sh == {bst_pkg::IR_CAP_MSB, bst_pkg::IR_CAP_LSB});
   endproperty
   a_cap_ir: assert property (p_cap_ir) else $error("capture-ir pattern wrong");

   property p_ir_upd;
      $changed(s_q.ir) |-> ($past(s_q.st) == bst_pkg::ST_UPD_IR && $past(fall))
                        || $past(s_q.st) == bst_pkg::ST_TLR;
   endproperty
   a_ir_upd: assert property (p_ir_upd) else $error("instruction changed outside update");

   property p_ir_msb;
      rise && (s_q.st == bst_pkg::ST_SH_IR)
         |=> s_q.ir_sh[bst_pkg::IR_W-1] == $past(s_q.tdi_s2);
   endproperty
   a_ir_msb: assert property (p_ir_msb) else $error("shift did not enter at msb");

   property p_tdo_fall;
      $changed(o_tdo) || $rose(o_tdo_oe) |-> $past(fall);
   endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("serial out moved off falling edge");

   property p_tdo_hiz;
      fall && !(s_q.st inside {bst_pkg::ST_SH_IR, bst_pkg::ST_SH_DR}) |=> !o_tdo_oe;
   endproperty
   a_tdo_hiz: assert property (p_tdo_hiz) else $error("serial out driven outside shift");

   property p_byp_cap;
      rise && (s_q.st == bst_pkg::ST_CAP_DR) |=> (s_q.byp == bst_pkg::BYP_CAP);
   endproperty
   a_byp_cap: assert property (p_byp_cap) else $error("bypass did not capture zero");

   property p_id_cap;
      rise && (s_q.st == bst_pkg::ST_CAP_DR) && (s_q.ir == bst_pkg::INS_IDCODE)
         |=> (s_q.idr == bst_pkg::ID_CODE);
   endproperty
   a_id_cap: assert property (p_id_cap) else $error("id code not captured");

   property p_sampz;
      (s_q.ir == bst_pkg::INS_SAMPZ) |-> !o_q_oe;
   endproperty
   a_sampz: assert property (p_sampz) else $error("outputs not floated");

   property p_ext_oe;
      (s_q.ir == bst_pkg::INS_EXTEST) |-> (o_q_oe == o_pins_pre[bst_pkg::OE_BIT]);
   endproperty
   a_ext_oe: assert property (p_ext_oe) else $error("enable cell not steering outputs");

   property p_bsr_cap;
      rise && (s_q.st == bst_pkg::ST_CAP_DR) && bsr_ins |=> (s_q.bsr == $past(s_q.pin_s2));
   endproperty
   a_bsr_cap: assert property (p_bsr_cap) else $error("boundary capture lost pin states");

   property p_oe_preset;
      (s_q.st == bst_pkg::ST_TLR) |=> (s_q.pre[bst_pkg::OE_BIT] == bst_pkg::OE_PRESET);
   endproperty
   a_oe_preset: assert property (p_oe_preset) else $error("enable latch not preset");

   // Preload may only move on the update fall, or by the reset preset of the enable cell
   property p_pre_upd;
      $changed(s_q.pre) |-> ($past(fall) && $past(s_q.st) == bst_pkg::ST_UPD_DR)
                         || $past(s_q.st) == bst_pkg::ST_TLR;
   endproperty
   a_pre_upd: assert property (p_pre_upd) else $error("preload changed outside update");

   property p_c_ir;
      rise && (s_q.st == bst_pkg::ST_UPD_IR);
   endproperty
   c_ir: cover property (p_c_ir);

   property p_c_ext;
      o_extest && o_q_oe;
   endproperty
   c_ext: cover property (p_c_ext);

   property p_c_mon;
      o_mon_valid && !i_mon_ready;
   endproperty
   c_mon: cover property (p_c_mon);

   property p_c_ovf;
      o_mon_ovf && o_mon_valid;
   endproperty
   c_ovf: cover property (p_c_ovf);

endmodule : bst_tap

// ### design/bst_pkg.sv
package bst_pkg;

   localparam int IR_W   = 3;
   localparam int ID_W   = 32;
   localparam int BSR_W  = 107;
   localparam int OE_BIT = 47;
   localparam int MON_W  = 8;
   localparam int MON_D  = 32;
   localparam int MON_CW = 3;

   localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
   localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
   localparam logic [IR_W-1:0] INS_SAMPZ  = 3'h2;
   localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
   localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

   localparam logic [1:0] IR_CAP_LSB = 2'h1;
   localparam logic       IR_CAP_MSB = 1'h0;
   localparam logic       BYP_CAP    = 1'h0;
   localparam logic       OE_PRESET  = 1'h0;
   localparam logic       PULL_UP    = 1'h1;
   localparam int         RST_TMS_N  = 5;

   // Identification value is arbitrary; bit 0 marks presence
   localparam logic [ID_W-1:0] ID_CODE = 32'h1234_5671;

   typedef enum logic [15:0] {
      ST_TLR    = 16'h0001,
      ST_RTI    = 16'h0002,
      ST_SEL_DR = 16'h0004,
      ST_CAP_DR = 16'h0008,
      ST_SH_DR  = 16'h0010,
      ST_EX1_DR = 16'h0020,
      ST_PA_DR  = 16'h0040,
      ST_EX2_DR = 16'h0080,
      ST_UPD_DR = 16'h0100,
      ST_SEL_IR = 16'h0200,
      ST_CAP_IR = 16'h0400,
      ST_SH_IR  = 16'h0800,
      ST_EX1_IR = 16'h1000,
      ST_PA_IR  = 16'h2000,
      ST_EX2_IR = 16'h4000,
      ST_UPD_IR = 16'h8000
   } bst_state_t;

endpackage : bst_pkg

// ### design/bst_fifo.sv
`timescale 1ns/1ps
module bst_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   input  wire logic         i_valid,
   output logic              o_ready,
   input  wire logic [W-1:0] i_data,
   output logic              o_valid,
   input  wire logic         i_ready,
   output logic [W-1:0]      o_data
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0]         wr;
      logic [AW:0]         rd;
   } bst_fifo_t;

   bst_fifo_t s_q, s_d;
   logic      full;
   logic      empty;

   assign empty   = (s_q.wr == s_q.rd);
   assign full    = (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]) && (s_q.wr[AW] != s_q.rd[AW]);
   assign o_ready = !full;
   assign o_valid = !empty;
   assign o_data  = s_q.mem[s_q.rd[AW-1:0]];

   always_comb begin
      s_d = s_q;
      if (i_valid && !full) begin
         s_d.mem[s_q.wr[AW-1:0]] = i_data;
         s_d.wr                  = s_q.wr + 1'b1;
      end
      if (i_ready && !empty) begin
         s_d.rd = s_q.rd + 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule : bst_fifo

// ### bench/bst_jtag_host.sv
`timescale 1ns/1ps
module bst_jtag_host (
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi,
   input  wire logic i_tdo
);
   localparam real HALF = 62.5;
   logic mon_q[$];

   initial begin
      // Test clock stands still between frames, idle lines at pull-up level
      o_tck = 1'h0;
      o_tms = 1'h1;
      o_tdi = 1'h1;
   end

   // Lines set in the low phase, TDO read just before the rise
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      o_tms = tms;
      o_tdi = tdi;
      #(HALF / 2);
      tdo = i_tdo;
      o_tck = 1'h1;
      #HALF;
      o_tck = 1'h0;
      #10;
      // Hold time spent: the line no longer shows the old bit
      o_tdi = ~tdi;
      #(HALF / 2 - 10);
   endtask : step

   task automatic tlr_reset();
      logic d;
      repeat (5) step(1'h1, 1'h1, d);
      step(1'h0, 1'h1, d);
   endtask : tlr_reset

   // Starts and ends in run-test-idle; only defined codes are ever loaded
   task automatic scan(input logic ir, input int n, input logic [127:0] din,
                       output logic [127:0] dout);
      logic d;
      dout = '0;
      step(1'h1, 1'h0, d);
      if (ir) step(1'h1, 1'h0, d);
      step(1'h0, 1'h0, d);
      step(1'h0, 1'h0, d);
      // Expected bit is queued before its rise, so the byte never outruns the queue
      for (int k = 0; k < n; k++) begin
         if (!ir) mon_q.push_back(din[k]);
         step(k == n - 1, din[k], d);
         dout[k] = d;
      end
      step(1'h1, 1'h0, d);
      step(1'h0, 1'h0, d);
   endtask : scan
endmodule : bst_jtag_host

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic                      i_clk, i_resetn, i_mon_ready, tck, tms, tdi;
   logic                      o_tdo, o_tdo_oe, o_extest, o_q_oe, o_mon_valid, o_mon_ovf;
   logic [bst_pkg::BSR_W-1:0] i_pins, o_pins_pre, pre_exp;
   logic [bst_pkg::MON_W-1:0] o_mon_data;
   logic [127:0]              so, si, rnd;
   logic [2:0]                codes [3];
   logic                      hold;
   wire                       tdo_w;
   int                        fail_count, cmp_count, seed, got;

   // No pull on the serial output: a released line shows the inverse of the last bit
   assign tdo_w = o_tdo_oe ? o_tdo : ~o_tdo;

   bst_tap u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_tck(tck), .i_tms(tms),
      .i_tdi(tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_pins(i_pins),
      .o_pins_pre(o_pins_pre), .o_extest(o_extest), .o_q_oe(o_q_oe),
      .o_mon_valid(o_mon_valid), .i_mon_ready(i_mon_ready), .o_mon_data(o_mon_data),
      .o_mon_ovf(o_mon_ovf));
   bst_jtag_host u_host (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo_w));

   initial begin
      i_clk = 1'h0;
      forever #2.5 i_clk = ~i_clk;
   end

   task automatic check(input string name, input logic [127:0] seen,
                        input logic [127:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   function automatic logic exp_q_oe(input logic [2:0] ins, input logic pre47);
      if (ins == bst_pkg::INS_SAMPZ) return 1'h0;
      if (ins == bst_pkg::INS_EXTEST) return pre47;
      return 1'h1;
   endfunction : exp_q_oe

   // Bytes leave in shift order, first bit at the LSB
   function automatic logic [7:0] next_byte();
      logic [7:0] b;
      for (int k = 0; k < 8; k++) b[k] = u_host.mon_q.pop_front();
      return b;
   endfunction : next_byte

   // Handshake judged at the fall, where valid, ready and data stand for the next rise
   always @(negedge i_clk) begin
      if (o_mon_valid === 1'h1 && i_mon_ready === 1'h1) begin
         check("mon_data", o_mon_data, next_byte());
         got++;
      end
   end

   always @(posedge i_clk) begin
      i_mon_ready <= !hold && (($random(seed) & 3) != 0);
   end

   task automatic sync();
      @(posedge i_clk);
      #1.3;
   endtask : sync

   initial begin
      #400us;
      fail_count++;
      give_verdict();
   end

   initial begin
      seed = 78111;
      fail_count = 0;
      cmp_count = 0;
      got = 0;
      hold = 1'h0;
      i_resetn = 1'h0;
      i_pins = '0;
      i_mon_ready = 1'h0;
      codes = '{bst_pkg::INS_SAMPLE, bst_pkg::INS_EXTEST, bst_pkg::INS_SAMPZ};
      repeat (6) @(posedge i_clk);
      i_resetn <= 1'h1;
      repeat (3) sync();
      check("tdo_oe", o_tdo_oe, 1'h0);
      check("pins_pre", o_pins_pre, '0);
      check("q_oe", o_q_oe, 1'h1);
      u_host.tlr_reset();
      u_host.scan(1'h0, 32, '1, so);
      check("id", so[31:0], bst_pkg::ID_CODE);
      u_host.scan(1'h1, 3, bst_pkg::INS_BYPASS, so);
      check("ir_cap", so[2:0], {bst_pkg::IR_CAP_MSB, bst_pkg::IR_CAP_LSB});
      si = {$random(seed), $random(seed), $random(seed), $random(seed)};
      u_host.scan(1'h0, 9, si, so);
      check("bypass", so[8:0], {si[7:0], bst_pkg::BYP_CAP});
      pre_exp = '0;
      for (int i = 0; i < 3; i++) begin
         rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
         @(posedge i_clk);
         i_pins <= rnd[106:0];
         #1.3;
         u_host.scan(1'h1, 3, codes[i], so);
         check("extest", o_extest, codes[i] == bst_pkg::INS_EXTEST);
         check("q_oe", o_q_oe, exp_q_oe(codes[i], pre_exp[47]));
         si = {$random(seed), $random(seed), $random(seed), $random(seed)};
         si[bst_pkg::OE_BIT] = codes[i] == bst_pkg::INS_EXTEST;
         u_host.scan(1'h0, bst_pkg::BSR_W, si, so);
         check("bsr", so[106:0], rnd[106:0]);
         if (codes[i] != bst_pkg::INS_SAMPZ) pre_exp = si[106:0];
         check("pins_pre", o_pins_pre, pre_exp);
         check("q_oe", o_q_oe, exp_q_oe(codes[i], pre_exp[47]));
      end
      u_host.tlr_reset();
      pre_exp[bst_pkg::OE_BIT] = bst_pkg::OE_PRESET;
      check("pins_pre", o_pins_pre, pre_exp);
      check("extest", o_extest, 1'h0);
      u_host.scan(1'h0, 32, '0, so);
      check("id", so[31:0], bst_pkg::ID_CODE);
      check("mon_ovf", o_mon_ovf, 1'h0);
      // Consumer stalls while the scan keeps arriving, so the FIFO must refuse
      hold = 1'h1;
      sync();
      got = 0;
      u_host.scan(1'h1, 3, bst_pkg::INS_BYPASS, so);
      repeat (3) u_host.scan(1'h0, 96,
         {$random(seed), $random(seed), $random(seed), $random(seed)}, so);
      check("mon_ovf", o_mon_ovf, 1'h1);
      check("mon_valid", o_mon_valid, 1'h1);
      hold = 1'h0;
      for (int t = 0; t < 1000 && o_mon_valid !== 1'h0; t++) sync();
      check("mon_valid", o_mon_valid, 1'h0);
      // FIFO depth plus the one byte waiting in the stager
      check("mon_count", got, bst_pkg::MON_D + 1);
      give_verdict();
   end
endmodule : testbench
